/* File: dv/fbec_erase_cmd_bench.sv */
`timescale 1ns/1ps
module fbec_erase_cmd_bench;
  import fbec_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  fbec_byte_s rxIn = '0;
  fbec_byte_s txOut;
  logic txReady, loadStart, eraseStart, highVoltBusy;
  logic loadDone = 1'b0, loadFail = 1'b0, eraseDone = 1'b0;
  logic bootAreaSel = 1'b0;
  logic [7:0] userBlockCount = 8'h10;
  logic [7:0] eraseBlock, lastBlk;
  int failures = 0, nTests = 0, nLoad = 0, nErase = 0;
  // Longer than 100 us of 25 ns cycles
  localparam int RST_HOLD = 100_000 / 25 + 1;
  fbec_erase_cmd dut (.clk_sys(clk_sys), .rst(rst), .rxIn(rxIn),
    .txReady(txReady), .loadDone(loadDone), .loadFail(loadFail),
    .eraseDone(eraseDone), .userBlockCount(userBlockCount),
    .bootAreaSel(bootAreaSel), .txOut(txOut), .loadStart(loadStart),
    .eraseStart(eraseStart), .eraseBlock(eraseBlock),
    .highVoltBusy(highVoltBusy));
  fbec_host host (.clk_sys(clk_sys), .rst(rst), .txOut(txOut),
    .slow(slow), .txReady(txReady));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (loadStart === 1'b1) nLoad++;
    if (eraseStart === 1'b1) begin
      nErase++;
      lastBlk = eraseBlock;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    rxIn <= '{valid: 1'b1, data: b};
    @(posedge clk_sys);
    rxIn <= '0;
  endtask
  // Order: loadDone, loadFail, eraseDone
  task automatic pulse(input logic [2:0] p);
    repeat (4) @(posedge clk_sys);
    {loadDone, loadFail, eraseDone} <= p;
    @(posedge clk_sys);
    {loadDone, loadFail, eraseDone} <= 3'h0;
  endtask
  task automatic reply(input logic [7:0] b0, b1, input int n);
    int i;
    for (i = 0; i < 200 && host.got.size() < n; i++) begin
      @(posedge clk_sys);
    end
    if (host.got.size() < n) begin
      failures++;
      give_verdict();
    end else begin
      repeat (4) @(posedge clk_sys);
      chk("replyLen", 8'(host.got.size()), 8'(n));
      chk("reply0", host.got[0], b0);
      if (n > 1) chk("reply1", host.got[1], b1);
      host.got.delete();
    end
  endtask
  task automatic frame(input logic [7:0] sz, blk, adj);
    send(CMD_BLK_ERASE);
    send(sz);
    send(blk);
    send(8'h00 - CMD_BLK_ERASE - sz - blk + adj);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic selOk();
    nLoad = 0;
    send(CMD_SEL_ERASE);
    pulse(3'h4);
    chk("loadStart", 8'(nLoad), 8'h01);
    reply(RSP_ACK, ZERO_BYTE, 1);
  endtask
  task automatic selFail();
    nLoad = 0;
    slow <= 1'b1;
    send(CMD_SEL_ERASE);
    pulse(3'h2);
    chk("loadStart", 8'(nLoad), 8'h01);
    reply(RSP_SEL_ERR, ERR_SEL_XFER, 2);
    slow <= 1'b0;
  endtask
  task automatic blkOk();
    nErase = 0;
    frame(BLK_SIZE_FIXED, 8'h0F, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk("eraseCnt", 8'(nErase), 8'h01);
    chk("eraseBlock", lastBlk, 8'h0F);
    chk("hvBusy", {7'h00, highVoltBusy}, 8'h01);
    chk("early", 8'(host.got.size()), 8'h00);
    pulse(3'h1);
    reply(RSP_ACK, ZERO_BYTE, 1);
    chk("hvIdle", {7'h00, highVoltBusy}, 8'h00);
  endtask
  task automatic blkErr(input logic [7:0] sz, blk, adj, code);
    nErase = 0;
    frame(sz, blk, adj);
    reply(RSP_BLK_ERR, code, 2);
    chk("noErase", 8'(nErase), 8'h00);
  endtask
  // Accidental reset while the array is under high voltage
  task automatic hvReset();
    frame(BLK_SIZE_FIXED, 8'h05, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk("hvBefore", {7'h00, highVoltBusy}, 8'h01);
    rst <= 1'b1;
    repeat (RST_HOLD) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("rstIdle", {4'h0, txOut.valid, loadStart, eraseStart,
      highVoltBusy}, 8'h00);
    chk("rstNoReply", 8'(host.got.size()), 8'h00);
  endtask
  task automatic bootErr();
    bootAreaSel <= 1'b1;
    blkErr(BLK_SIZE_FIXED, 8'h03, 8'h00, ERR_BLOCK);
    bootAreaSel <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("idle", {4'h0, txOut.valid, loadStart, eraseStart, highVoltBusy},
      8'h00);
    selOk();
    selFail();
    blkOk();
    hvReset();
    blkErr(BLK_SIZE_FIXED, 8'h02, 8'h01, ERR_CHECKSUM);
    blkErr(8'h02, 8'h02, 8'h00, ERR_SIZE);
    blkErr(BLK_SIZE_FIXED, 8'h10, 8'h00, ERR_BLOCK);
    bootErr();
    give_verdict();
  end
endmodule

/* File: dv/fbec_host.sv */
`timescale 1ns/1ps
module fbec_host (
  input wire logic clk_sys,
  input wire logic rst,
  input fbec_pkg::fbec_byte_s txOut,
  input wire logic slow,
  output logic txReady
);
  logic [7:0] got[$];
  // Takes a reply byte where ready meets valid
  always @(posedge clk_sys) begin
    if (rst) begin
      txReady <= 1'b0;
    end else begin
      if (txOut.valid && txReady) begin
        got.push_back(txOut.data);
      end
      txReady <= slow ? ~txReady : 1'b1;
    end
  end
endmodule

/* File: inc/fbec_pkg.sv */
package fbec_pkg;
  localparam logic [7:0] CMD_SEL_ERASE = 8'h48;
  localparam logic [7:0] CMD_BLK_ERASE = 8'h58;
  localparam logic [7:0] RSP_ACK = 8'h06;
  localparam logic [7:0] RSP_SEL_ERR = 8'hC8;
  localparam logic [7:0] RSP_BLK_ERR = 8'hD8;
  localparam logic [7:0] ERR_SEL_XFER = 8'h54;
  localparam logic [7:0] ERR_CHECKSUM = 8'h11;
  localparam logic [7:0] ERR_BLOCK = 8'h29;
  localparam logic [7:0] ERR_SIZE = 8'h2A;
  localparam logic [7:0] BLK_SIZE_FIXED = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] BYTE_ONE = 2'h1;
  localparam logic [1:0] BYTE_TWO = 2'h2;
  localparam logic [1:0] BYTE_THREE = 2'h3;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fbec_byte_s;
endpackage

/* File: verilog/fbec_erase_cmd.sv */
`timescale 1ns/1ps
module fbec_erase_cmd
  import fbec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input fbec_pkg::fbec_byte_s rxIn,
  input wire logic txReady,
  input wire logic loadDone,
  input wire logic loadFail,
  input wire logic eraseDone,
  input wire logic [7:0] userBlockCount,
  input wire logic bootAreaSel,
  output fbec_pkg::fbec_byte_s txOut,
  output logic loadStart,
  output logic eraseStart,
  output logic [7:0] eraseBlock,
  output logic highVoltBusy
);
  import fbec_pkg::*;

  typedef enum {IDLE, LOADING, FRAME, ERASING, REPLY} fbec_state_e;

  function automatic logic [7:0] addByte(input logic [7:0] a,
                                         input logic [7:0] b);
    addByte = a + b;
  endfunction

  fbec_state_e state, next_state;
  logic [1:0] idx, next_idx;
  logic [7:0] sum, next_sum;
  logic [7:0] sizeByte, next_sizeByte;
  logic next_loadStart, next_eraseStart, next_highVoltBusy;
  logic [7:0] next_eraseBlock;
  logic sendOne, sendTwo, txBusy;
  logic [7:0] firstByte, secondByte;

  ////////////////////////////////////////////////////////////////////
  // Command decode and sequencing
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_sum = sum;
    next_sizeByte = sizeByte;
    next_loadStart = 1'b0;
    next_eraseStart = 1'b0;
    next_eraseBlock = eraseBlock;
    next_highVoltBusy = highVoltBusy;
    sendOne = 1'b0;
    sendTwo = 1'b0;
    firstByte = RSP_ACK;
    secondByte = ZERO_BYTE;
    case (state)
      IDLE: begin
        if (rxIn.valid && !txBusy) begin
          if (rxIn.data == CMD_SEL_ERASE) begin
            next_loadStart = 1'b1;
            next_state = LOADING;
          end else if (rxIn.data == CMD_BLK_ERASE) begin
            next_sum = rxIn.data;
            next_idx = BYTE_ONE;
            next_state = FRAME;
          end
        end
      end
      LOADING: begin
        if (loadFail) begin
          sendTwo = 1'b1;
          firstByte = RSP_SEL_ERR;
          secondByte = ERR_SEL_XFER;
          next_state = REPLY;
        end else if (loadDone) begin
          sendOne = 1'b1;
          next_state = REPLY;
        end
      end
      FRAME: begin
        if (rxIn.valid) begin
          next_sum = addByte(sum, rxIn.data);
          next_idx = idx + BYTE_ONE;
          if (idx == BYTE_ONE) begin
            next_sizeByte = rxIn.data;
          end
          if (idx == BYTE_TWO) begin
            next_eraseBlock = rxIn.data;
          end
          if (idx == BYTE_THREE) begin
            firstByte = RSP_BLK_ERR;
            if (addByte(sum, rxIn.data) != ZERO_BYTE) begin
              sendTwo = 1'b1;
              secondByte = ERR_CHECKSUM;
              next_state = REPLY;
            end else if (sizeByte != BLK_SIZE_FIXED) begin
              sendTwo = 1'b1;
              secondByte = ERR_SIZE;
              next_state = REPLY;
            end else if (bootAreaSel ||
                         eraseBlock >= userBlockCount) begin
              sendTwo = 1'b1;
              secondByte = ERR_BLOCK;
              next_state = REPLY;
            end else begin
              next_eraseStart = 1'b1;
              next_highVoltBusy = 1'b1;
              next_state = ERASING;
            end
          end
        end
      end
      ERASING: begin
        if (eraseDone) begin
          sendOne = 1'b1;
          next_highVoltBusy = 1'b0;
          next_state = REPLY;
        end
      end
      REPLY: begin
        if (!txBusy) begin
          next_state = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= IDLE;
      idx <= 2'h0;
      sum <= ZERO_BYTE;
      sizeByte <= ZERO_BYTE;
      loadStart <= 1'b0;
      eraseStart <= 1'b0;
      eraseBlock <= ZERO_BYTE;
      highVoltBusy <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      sum <= next_sum;
      sizeByte <= next_sizeByte;
      loadStart <= next_loadStart;
      eraseStart <= next_eraseStart;
      eraseBlock <= next_eraseBlock;
      highVoltBusy <= next_highVoltBusy;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reply sender
  fbec_tx_reply u_reply (
    .clk_sys(clk_sys),
    .rst(rst),
    .sendOne(sendOne),
    .sendTwo(sendTwo),
    .firstByte(firstByte),
    .secondByte(secondByte),
    .txReady(txReady),
    .txOut(txOut),
    .busy(txBusy)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks
  sequence selCmd;
    state == IDLE && rxIn.valid && !txBusy && rxIn.data == CMD_SEL_ERASE;
  endsequence

  a_sel_load: assert property (
    @(posedge clk_sys) disable iff (rst)
    selCmd |=> loadStart && state == LOADING)
    else $error("Selection did not start load");

  a_ack_after_load: assert property (
    @(posedge clk_sys) disable iff (rst)
    state == LOADING && loadDone && !loadFail
    |=> txOut.valid && txOut.data == RSP_ACK)
    else $error("Missing ack after load");

  a_sel_err_frame: assert property (
    @(posedge clk_sys) disable iff (rst)
    state == LOADING && loadFail
    |=> txOut.valid && txOut.data == RSP_SEL_ERR)
    else $error("Missing selection error byte");

  a_sel_err_code: assert property (
    @(posedge clk_sys) disable iff (rst)
    txOut.valid && txOut.data == RSP_SEL_ERR && txReady
    |=> txOut.valid && txOut.data == ERR_SEL_XFER)
    else $error("Wrong selection error code");

  a_erase_block: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(eraseStart) |-> eraseBlock < userBlockCount
    && $past(sizeByte) == BLK_SIZE_FIXED)
    else $error("Erase of invalid block");

  a_sum_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    eraseStart |-> $past(next_sum) == ZERO_BYTE)
    else $error("Erase with bad checksum");

  a_ack_after_erase: assert property (
    @(posedge clk_sys) disable iff (rst)
    state == ERASING && eraseDone
    |=> txOut.valid && txOut.data == RSP_ACK && !highVoltBusy)
    else $error("Missing ack after erase");

  a_no_early_ack: assert property (
    @(posedge clk_sys) disable iff (rst)
    state == ERASING && !eraseDone |=> !txOut.valid)
    else $error("Ack before erase finished");

  a_boot_refused: assert property (
    @(posedge clk_sys) disable iff (rst)
    state == FRAME && idx == BYTE_THREE && rxIn.valid && bootAreaSel
    |=> !eraseStart)
    else $error("Boot area erase started");
endmodule

/* File: verilog/fbec_tx_reply.sv */
`timescale 1ns/1ps
module fbec_tx_reply
  import fbec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sendOne,
  input wire logic sendTwo,
  input wire logic [7:0] firstByte,
  input wire logic [7:0] secondByte,
  input wire logic txReady,
  output fbec_pkg::fbec_byte_s txOut,
  output logic busy
);
  import fbec_pkg::*;

  fbec_byte_s next_txOut;
  logic [7:0] pend, next_pend;
  logic hasPend, next_hasPend;
  logic next_busy;

  always_comb begin
    next_txOut = txOut;
    next_pend = pend;
    next_hasPend = hasPend;
    next_busy = busy;
    if (txOut.valid && txReady) begin
      if (hasPend) begin
        next_txOut.data = pend;
        next_hasPend = 1'b0;
      end else begin
        next_txOut.valid = 1'b0;
        next_busy = 1'b0;
      end
    end
    if (!busy && (sendOne || sendTwo)) begin
      next_txOut.valid = 1'b1;
      next_txOut.data = firstByte;
      next_pend = secondByte;
      next_hasPend = sendTwo;
      next_busy = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txOut <= '0;
      pend <= ZERO_BYTE;
      hasPend <= 1'b0;
      busy <= 1'b0;
    end else begin
      txOut <= next_txOut;
      pend <= next_pend;
      hasPend <= next_hasPend;
      busy <= next_busy;
    end
  end

  a_tx_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    txOut.valid && !txReady |=> txOut.valid && $stable(txOut.data))
    else $error("Reply byte changed while stalled");
endmodule
